//--- eprom_model.sv
// behavioural 512 by 8 eprom answering the programmer in program mode
`timescale 1ns/1ps
module eprom_model
#(
    parameter int SETUP_NS = 40,
    parameter int HOLD_NS  = 40,
    parameter int PULSE_NS = 200
)
(
    input  wire logic [8:0] word_address_i,
    input  wire logic       strobe_n_i,
    input  wire logic       program_i,
    input  wire logic       pulse_i,
    input  wire logic       select_i,
    input  wire logic [7:0] data_i,
    input  wire logic       oe_i,
    output logic      [7:0] q_o
);
    logic [7:0] mem [512];
    logic [8:0] addr_q;
    logic [7:0] stuck_mask = 8'h00;
    int         weak_left  = 0;
    int         access_ns  = 1000;
    int         viol       = 0;
    int         gen        = 0;
    int         n_pulse    = 0;
    realtime    t_srise = 0, t_sfall = 0, t_prise = 0, t_pfall = -1e9;
    realtime    t_data  = 0;

    initial begin
        for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
        q_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // strobe and address latch
    always @(posedge strobe_n_i) t_srise = $realtime;
    always @(negedge strobe_n_i) begin
        if ($realtime - t_srise < 150.0) viol++;
        if (program_i !== 1'b1 || select_i !== 1'b1) viol++;
        addr_q  = word_address_i;
        t_sfall = $realtime;
    end
    always @(word_address_i)
        if (strobe_n_i === 1'b0 && $realtime - t_sfall < 100.0) viol++;
    ////////////////////////////////////////////////////////////////////////
    // data window and program pulse
    always @(data_i, oe_i) begin
        if (pulse_i === 1'b1 || $realtime - t_pfall < HOLD_NS) viol++;
        t_data = $realtime;
    end
    always @(posedge pulse_i) begin
        if (oe_i !== 1'b1 || $realtime - t_data < SETUP_NS) viol++;
        if ($realtime - t_pfall < (t_pfall - t_prise) / 3.0) viol++;
        t_prise = $realtime;
        n_pulse++;
    end
    always @(negedge pulse_i) if (n_pulse > 0) begin
        t_pfall = $realtime;
        if (t_pfall - t_prise != PULSE_NS) viol++;
        if (weak_left > 0) weak_left--;
        else mem[addr_q] = mem[addr_q] & (data_i | stuck_mask);
    end
    ////////////////////////////////////////////////////////////////////////
    // outputs: invalid pattern until the access time has run
    always @(strobe_n_i, select_i) begin
        gen++;
        q_o = ~q_o;
        if (strobe_n_i === 1'b0 && select_i === 1'b0) fork
            show(gen);
        join_none
    end
    task automatic show(input int g);
        #(access_ns);
        if (g == gen) q_o = mem[addr_q];
    endtask
endmodule // eprom_model

//--- eprom_prog_defs.svh
// timing constants and field widths for the eprom programmer
`ifndef EPROM_PROG_DEFS_SVH
`define EPROM_PROG_DEFS_SVH
`define CLK_PERIOD_NS        10
`define ADDR_W               9
`define DATA_W               8
`define WORDS                512
`define ERASED_WORD          8'hFF
`define STROBE_HIGH_NS       150
`define STROBE_HIGH_CYC      ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_HOLD_NS         100
`define ADDR_HOLD_CYC        ((`ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_TO_DATA_NS    1000
`define STROBE_TO_DATA_CYC   ((`STROBE_TO_DATA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_SETUP_US        9
`define DATA_SETUP_CYC       ((`DATA_SETUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_HOLD_US         9
`define DATA_HOLD_CYC        ((`DATA_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_NOM_MS         20
`define PULSE_CYC            (`PULSE_NOM_MS * 1000000 / `CLK_PERIOD_NS)
`define DUTY_MAX_PCT         75
`define PULSE_GAP_CYC        ((`PULSE_CYC * (100 - `DUTY_MAX_PCT) + `DUTY_MAX_PCT - 1) / `DUTY_MAX_PCT)
`define RETRY_LIMIT          8
`endif

//--- eprom_prog_pkg.sv
// types for the eprom programmer
package eprom_prog_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_DSETUP,
        ST_PULSE, ST_DHOLD, ST_GAP, ST_VERIFY, ST_DONE
    } prog_state_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } prog_req_t;

    typedef struct packed {
        logic       done;
        logic       fail;
        logic [3:0] tries;
        logic [7:0] readback;
    } prog_rsp_t;
endpackage

//--- eprom_programmer.sv
// program and verify sequencer driving a 512 by 8 uv eprom
// What this block does
// - the strobe stays high 150 ns before its fall and address holds 100 ns.
// - address is set and program and select are high before the strobe falls.
// - the program pulse comes only while driven data is valid.
// - each program pulse lasts 20 ms, within 18 to 22 ms.
// - the pulse duty cycle stays at or under 75 percent.
// - data is stable 9 us before the pulse and 9 us after it.
// - each word is read; only a word that still needs bits cleared goes through program and verify steps.
// - words may be programmed in any order the user asks.
`timescale 1ns/1ps
`include "eprom_prog_defs.svh"
module eprom_programmer
    import eprom_prog_pkg::*;
#(
    parameter int PULSE_CYC   = `PULSE_CYC,
    parameter int GAP_CYC     = `PULSE_GAP_CYC,
    parameter int SETUP_CYC   = `DATA_SETUP_CYC,
    parameter int HOLD_CYC    = `DATA_HOLD_CYC,
    parameter int RETRY_LIMIT = `RETRY_LIMIT
)
(
    input  wire logic      ref_clk_i,
    input  wire logic      reset_i,
    input  wire logic      req_valid_i,
    output logic           req_ready_o,
    input  wire prog_req_t req_i,
    output prog_rsp_t      rsp_o,
    output logic [8:0]     word_address_o,
    output logic           address_strobe_n_o,
    output logic           program_o,
    output logic           program_pulse_o,
    output logic           select_o,
    output logic [7:0]     data_lines_o,
    output logic           data_lines_oe_o,
    input  wire logic [7:0] data_lines_i
);
    localparam int CW = 32;
    localparam int STROBE_CYC = `STROBE_HIGH_CYC;
    localparam int AHOLD_CYC  = `ADDR_HOLD_CYC;
    localparam int ACCESS_CYC = `STROBE_TO_DATA_CYC + 4;

    initial begin
        if (`ADDR_W != 9 || `DATA_W != 8 || RETRY_LIMIT < 1 ||
            RETRY_LIMIT > 15 || PULSE_CYC < 1 || SETUP_CYC < 1 ||
            HOLD_CYC < 1 || GAP_CYC * `DUTY_MAX_PCT <
            PULSE_CYC * (100 - `DUTY_MAX_PCT)) begin
            $error("eprom_programmer parameters out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data line input synchroniser
    logic [7:0] rd_sync;
    eprom_sync2 #(.WIDTH(8)) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   (data_lines_i),
        .sync_o    (rd_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer state
    prog_state_t   state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [8:0]    addr_ff, nxt_addr;
    logic [7:0]    want_ff, nxt_want;
    logic [7:0]    drive_ff, nxt_drive;
    logic [7:0]    rb_ff, nxt_rb;
    logic [3:0]    tries_ff, nxt_tries;
    logic          done_ff, nxt_done;
    logic          fail_ff, nxt_fail;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff + 32'h1;
        nxt_addr  = addr_ff;
        nxt_want  = want_ff;
        nxt_drive = drive_ff;
        nxt_rb    = rb_ff;
        nxt_tries = tries_ff;
        nxt_done  = 1'b0;
        nxt_fail  = fail_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_cnt = '0;
                if (req_valid_i) begin
                    nxt_addr  = req_i.addr;
                    nxt_want  = req_i.data;
                    nxt_tries = 4'h0;
                    nxt_fail  = 1'b0;
                    nxt_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                nxt_cnt   = '0;
                nxt_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (cnt_ff >= CW'(STROBE_CYC - 1)) begin
                    nxt_cnt   = '0;
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_ff >= CW'(ACCESS_CYC - 1) &&
                    cnt_ff >= CW'(AHOLD_CYC - 1)) begin
                    nxt_rb    = rd_sync;
                    nxt_cnt   = '0;
                    nxt_state = ST_READ;
                end
            end
            ST_READ: begin
                nxt_cnt = '0;
                if ((rb_ff & want_ff) != want_ff) begin
                    nxt_fail  = 1'b1;
                    nxt_state = ST_DONE;
                end else if (rb_ff == want_ff) begin
                    nxt_state = ST_DONE;
                end else begin
                    nxt_drive = want_ff | ~rb_ff;
                    nxt_state = ST_DSETUP;
                end
            end
            ST_DSETUP: begin
                if (cnt_ff >= CW'(SETUP_CYC - 1)) begin
                    nxt_cnt   = '0;
                    nxt_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (cnt_ff >= CW'(PULSE_CYC - 1)) begin
                    nxt_cnt   = '0;
                    nxt_tries = tries_ff + 4'h1;
                    nxt_state = ST_DHOLD;
                end
            end
            ST_DHOLD: begin
                if (cnt_ff >= CW'(HOLD_CYC - 1)) begin
                    nxt_cnt   = '0;
                    nxt_state = ST_GAP;
                end
            end
            ST_GAP: begin
                if (cnt_ff >= CW'(GAP_CYC - 1)) begin
                    nxt_cnt   = '0;
                    nxt_state = ST_VERIFY;
                end
            end
            ST_VERIFY: begin
                if (cnt_ff >= CW'(ACCESS_CYC - 1)) begin
                    nxt_rb  = rd_sync;
                    nxt_cnt = '0;
                    if (rd_sync == want_ff) begin
                        nxt_state = ST_DONE;
                    end else if (tries_ff >= 4'(RETRY_LIMIT)) begin
                        nxt_fail  = 1'b1;
                        nxt_state = ST_DONE;
                    end else begin
                        nxt_drive = want_ff | ~rd_sync;
                        nxt_state = ST_DSETUP;
                    end
                end
            end
            ST_DONE: begin
                nxt_done  = 1'b1;
                nxt_cnt   = '0;
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
            addr_ff  <= 9'h000;
            want_ff  <= 8'hFF;
            drive_ff <= 8'hFF;
            rb_ff    <= 8'hFF;
            tries_ff <= 4'h0;
            done_ff  <= 1'b0;
            fail_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            addr_ff  <= nxt_addr;
            want_ff  <= nxt_want;
            drive_ff <= nxt_drive;
            rb_ff    <= nxt_rb;
            tries_ff <= nxt_tries;
            done_ff  <= nxt_done;
            fail_ff  <= nxt_fail;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive
    logic strobe_low;
    logic driving;
    assign strobe_low = (state_ff != ST_IDLE) && (state_ff != ST_SETUP) &&
                        (state_ff != ST_STROBE) && (state_ff != ST_DONE);
    assign driving    = (state_ff == ST_DSETUP) || (state_ff == ST_PULSE) ||
                        (state_ff == ST_DHOLD);

    assign req_ready_o        = (state_ff == ST_IDLE);
    assign word_address_o     = addr_ff;
    assign address_strobe_n_o = ~strobe_low;
    assign program_o          = 1'b1;
    assign select_o           = ~((state_ff == ST_HOLD && cnt_ff != '0) ||
                                  state_ff == ST_VERIFY);
    assign program_pulse_o    = (state_ff == ST_PULSE);
    assign data_lines_o       = drive_ff;
    assign data_lines_oe_o    = driving;
    assign rsp_o.done         = done_ff;
    assign rsp_o.fail         = fail_ff;
    assign rsp_o.tries        = tries_ff;
    assign rsp_o.readback     = rb_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_pulse_data;
        @(posedge ref_clk_i) disable iff (reset_i)
        program_pulse_o |-> data_lines_oe_o && !address_strobe_n_o;
    endproperty
    a_pulse_data: assert property (p_pulse_data)
        else $error("pulse without driven data");

    property p_pulse_len;
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(program_pulse_o) |-> state_ff == ST_DHOLD &&
            $past(cnt_ff) == CW'(PULSE_CYC - 1);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("pulse ended off schedule");

    property p_setup;
        @(posedge ref_clk_i) disable iff (reset_i)
        $rose(program_pulse_o) |-> $past(data_lines_oe_o) &&
            $stable(data_lines_o);
    endproperty
    a_setup: assert property (p_setup)
        else $error("data not set up before pulse");

    property p_hold;
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(program_pulse_o) |-> data_lines_oe_o && $stable(data_lines_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("data released at pulse end");

    property p_gap;
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(data_lines_oe_o) |-> !program_pulse_o [*8];
    endproperty
    a_gap: assert property (p_gap)
        else $error("pulse gap too short");

    property p_strobe_high;
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(address_strobe_n_o) |-> $past(address_strobe_n_o, 8);
    endproperty
    a_strobe_high: assert property (p_strobe_high)
        else $error("strobe high time short");

    property p_addr_hold;
        @(posedge ref_clk_i) disable iff (reset_i)
        !address_strobe_n_o |-> $stable(word_address_o);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address changed during hold");

    property p_prog_high;
        @(posedge ref_clk_i) disable iff (reset_i)
        $fell(address_strobe_n_o) |-> program_o && select_o && $past(select_o);
    endproperty
    a_prog_high: assert property (p_prog_high)
        else $error("program or select low at strobe");

    property p_retry;
        @(posedge ref_clk_i) disable iff (reset_i)
        program_pulse_o |-> tries_ff < 4'(RETRY_LIMIT);
    endproperty
    a_retry: assert property (p_retry)
        else $error("retry limit exceeded");

    c_pulse: cover property (@(posedge ref_clk_i) $rose(program_pulse_o));
    c_done:  cover property (@(posedge ref_clk_i) rsp_o.done && !rsp_o.fail);
    c_fail:  cover property (@(posedge ref_clk_i) rsp_o.done && rsp_o.fail);
    c_retry: cover property (@(posedge ref_clk_i)
                             program_pulse_o && tries_ff == 4'h1);
endmodule // eprom_programmer

//--- eprom_sync2.sv
// two flip-flop synchroniser for the eprom data lines
`timescale 1ns/1ps
module eprom_sync2
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("eprom_sync2 width must be positive");
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // eprom_sync2

//--- uv_eprom_program_sequence_tb_top.sv
// self-checking bench for the eprom program and verify sequencer
`timescale 1ns/1ps
module uv_eprom_program_sequence_tb_top;
    import eprom_prog_pkg::*;
    logic       ref_clk_i   = 1'b0;
    logic       reset_i     = 1'b1;
    logic       req_valid_i = 1'b0;
    prog_req_t  req_i       = '0;
    logic       req_ready_o, address_strobe_n_o, program_o;
    logic       program_pulse_o, select_o, data_lines_oe_o;
    prog_rsp_t  rsp_o;
    logic [8:0] word_address_o;
    logic [7:0] data_lines_o, q_dev;
    wire  [7:0] data_lines_i = data_lines_oe_o ? data_lines_o : q_dev;
    int         miscompares = 0;
    int         n_tests     = 0;
    int         pulse_cyc   = 0;
    int         n_pulses    = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    eprom_programmer #(.PULSE_CYC(20), .GAP_CYC(8), .SETUP_CYC(4),
        .HOLD_CYC(4), .RETRY_LIMIT(8)) uut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_i(req_i), .rsp_o(rsp_o),
        .word_address_o(word_address_o),
        .address_strobe_n_o(address_strobe_n_o), .program_o(program_o),
        .program_pulse_o(program_pulse_o), .select_o(select_o),
        .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
        .data_lines_i(data_lines_i));

    eprom_model far_dev (
        .word_address_i(word_address_o), .strobe_n_i(address_strobe_n_o),
        .program_i(program_o), .pulse_i(program_pulse_o),
        .select_i(select_o), .data_i(data_lines_i),
        .oe_i(data_lines_oe_o), .q_o(q_dev));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // pulse width in clock cycles, checked at each fall
    always @(posedge ref_clk_i) begin
        if (program_pulse_o === 1'b1) pulse_cyc <= pulse_cyc + 1;
        else if (pulse_cyc != 0) begin
            check("pulse_width", 16'(pulse_cyc), 16'd20);
            n_pulses  <= n_pulses + 1;
            pulse_cyc <= 0;
        end
    end

    task automatic program_word(input logic [8:0] a, input logic [7:0] d,
                                input logic f, input logic [3:0] t,
                                input logic [7:0] rb);
        int n;
        int p0;
        n  = 0;
        p0 = n_pulses;
        @(negedge ref_clk_i);
        while (req_ready_o !== 1'b1 && n < 100) begin
            @(negedge ref_clk_i);
            n++;
        end
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_i       <= {a, d};
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        while (rsp_o.done !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        check("done", 16'(rsp_o.done), 16'h1);
        check("fail", 16'(rsp_o.fail), 16'(f));
        check("tries", 16'(rsp_o.tries), 16'(t));
        check("readback", 16'(rsp_o.readback), 16'(rb));
        check("address", 16'(word_address_o), 16'(a));
        repeat (2) @(negedge ref_clk_i);
        check("pulses", 16'(n_pulses - p0), 16'(t));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("idle_pins", 16'({req_ready_o, address_strobe_n_o,
              program_pulse_o, data_lines_oe_o, program_o}), 16'h19);
    endtask

    task automatic t_program_and_refuse();
        program_word(9'h1FF, 8'hA5, 1'b0, 4'h1, 8'hA5);
        check("cell", 16'(far_dev.mem[9'h1FF]), 16'h00A5);
        program_word(9'h1FF, 8'hA5, 1'b0, 4'h0, 8'hA5);
        program_word(9'h1FF, 8'hFF, 1'b1, 4'h0, 8'hA5);
    endtask

    task automatic t_any_order();
        far_dev.access_ns = 300;
        program_word(9'h000, 8'h00, 1'b0, 4'h1, 8'h00);
        far_dev.access_ns = 1000;
        program_word(9'h100, 8'h3C, 1'b0, 4'h1, 8'h3C);
        check("cell_lo", 16'(far_dev.mem[9'h000]), 16'h0000);
    endtask

    task automatic t_retry();
        far_dev.weak_left = 2;
        program_word(9'h003, 8'h0F, 1'b0, 4'h3, 8'h0F);
        far_dev.stuck_mask = 8'h01;
        program_word(9'h004, 8'h00, 1'b1, 4'h8, 8'h01);
        far_dev.stuck_mask = 8'h00;
    endtask

    initial begin
        repeat (16) @(posedge ref_clk_i);
        t_reset();
        reset_i <= 1'b0;
        t_program_and_refuse();
        t_any_order();
        t_retry();
        check("pin_timing", 16'(far_dev.viol), 16'h0);
        finish_test();
    end

    initial begin
        repeat (30000) @(posedge ref_clk_i);
        miscompares++;
        finish_test();
    end
endmodule // uv_eprom_program_sequence_tb_top
